/* File: hw/sdm_pkg.sv */
package sdm_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int SECT_W = 8;
    localparam int OFF_W = 8;
    localparam int NUM_SECTORS = 12;
    localparam int MEM_DEPTH = 1728;
    localparam int MEM_IDX_W = 11;
    localparam int SFR_ADDR_W = 8;
    localparam int BIT_SEL_W = 3;

    // ****************************************
    // sector map
    // ****************************************
    localparam logic [SECT_W-1:0] SECT_SFR_LAST = 8'h01;
    localparam logic [SECT_W-1:0] SECT_LCD = 8'h04;
    localparam logic [SECT_W-1:0] SECT_TK_A = 8'h05;
    localparam logic [SECT_W-1:0] SECT_TK_B = 8'h06;
    localparam logic [SECT_W-1:0] SECT_LIMIT = 8'h0C;
    localparam logic [OFF_W-1:0] OFF_GP_FIRST = 8'h80;
    localparam logic [OFF_W-1:0] OFF_SFR_LAST = 8'h7F;
    localparam logic [OFF_W-1:0] LCD_SIZE = 8'h30;
    localparam logic [OFF_W-1:0] TK_SIZE = 8'h48;

    // base of each region inside the shared storage array
    localparam logic [MEM_IDX_W-1:0] BASE_LCD = 11'h600;
    localparam logic [MEM_IDX_W-1:0] BASE_TK_A = 11'h630;
    localparam logic [MEM_IDX_W-1:0] BASE_TK_B = 11'h678;

    // ****************************************
    // pointer and indirect locations in sector 0
    // ****************************************
    localparam logic [OFF_W-1:0] OFF_IND_ONE = 8'h02;
    localparam logic [OFF_W-1:0] OFF_PTR_ONE_OFF = 8'h03;
    localparam logic [OFF_W-1:0] OFF_PTR_ONE_SECT = 8'h04;
    localparam logic [OFF_W-1:0] OFF_IND_TWO = 8'h0C;
    localparam logic [OFF_W-1:0] OFF_PTR_TWO_OFF = 8'h0D;
    localparam logic [OFF_W-1:0] OFF_PTR_TWO_SECT = 8'h0E;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

    typedef enum logic [1:0] {
        BOP_BYTE,
        BOP_SET,
        BOP_CLR,
        BOP_NONE
    } sdm_bop_t;

    typedef enum logic [2:0] {
        RGN_NONE,
        RGN_SFR,
        RGN_PTR,
        RGN_GP,
        RGN_LCD,
        RGN_TK
    } sdm_region_t;

    typedef enum logic [1:0] {
        PTR_ONE_OFF,
        PTR_ONE_SECT,
        PTR_TWO_OFF,
        PTR_TWO_SECT
    } sdm_ptr_sel_t;

    typedef enum logic {
        ST_IDLE,
        ST_MODIFY
    } sdm_state_t;
endpackage

/* File: hw/sdm_ram.sv */
module sdm_ram
    import sdm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [MEM_IDX_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    // contents are not reset, as in any plain ram
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (en_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (en_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule

/* File: hw/sdm_map.sv */
// Summary of operation
// - Every location in every sector is one byte, read and written whole or set or cleared a single bit at a time.
// - Offsets 00H to 7FH of sectors 0 and 1 decode as special-function space.
// - Offsets 80H to FFH of sectors 0 to 11 are general-purpose storage.
// - Display segment data sits in sector 4 starting at offset 00H.
// - Touch-sensing data sits in sectors 5 and 6, each starting at offset 00H.
// - Indirect access takes sector from a pointer sector register and offset from its pair.
// - Extended addresses are 12 bits, upper part sector and low byte offset.
// - Every implemented sector is reachable directly without pointers.
// - Reads of unused special-function locations return 00H.
// - Read-only and unused special-function locations ignore writes, others accept them.
// - Whole bytes are read and written, and single bits can be set or cleared.
module sdm_map
    import sdm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [1:0] bop_i,
    input wire logic [BIT_SEL_W-1:0] bit_sel_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic busy_o,
    output logic rvalid_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic sfr_rd_o,
    output logic sfr_we_o,
    output logic sfr_bank_o,
    output logic [SFR_ADDR_W-2:0] sfr_addr_o,
    output logic [DATA_W-1:0] sfr_wdata_o,
    input wire logic [DATA_W-1:0] sfr_rdata_i,
    input wire logic sfr_used_i,
    input wire logic sfr_ro_i,
    output logic [SECT_W-1:0] pointer_one_sector_reg_o,
    output logic [OFF_W-1:0] pointer_one_offset_reg_o,
    output logic [SECT_W-1:0] pointer_two_sector_reg_o,
    output logic [OFF_W-1:0] pointer_two_offset_reg_o
);
    // ****************************************
    // state
    // ****************************************
    sdm_state_t state;
    logic [SECT_W-1:0] pointer_one_sector_reg;
    logic [OFF_W-1:0] pointer_one_offset_reg;
    logic [SECT_W-1:0] pointer_two_sector_reg;
    logic [OFF_W-1:0] pointer_two_offset_reg;

    sdm_region_t cap_region;
    logic [MEM_IDX_W-1:0] cap_idx;
    sdm_ptr_sel_t cap_ptr;
    logic cap_bank;
    logic [SFR_ADDR_W-2:0] cap_sfr_addr;
    logic cap_sfr_wr_ok;
    logic [DATA_W-1:0] cap_hold;
    sdm_bop_t cap_bop;
    logic [BIT_SEL_W-1:0] cap_bit;
    logic rd_pend;

    // ****************************************
    // address formation
    // ****************************************
    logic [SECT_W-1:0] eff_sect;
    logic [OFF_W-1:0] eff_off;
    logic is_ind_one;
    logic is_ind_two;
    logic [SECT_W-1:0] dir_sect;
    logic [OFF_W-1:0] dir_off;

    assign dir_sect = {{(SECT_W-(ADDR_W-OFF_W)){1'b0}}, addr_i[ADDR_W-1:OFF_W]};
    assign dir_off = addr_i[OFF_W-1:0];
    assign is_ind_one = (dir_sect == ZERO_BYTE) && (dir_off == OFF_IND_ONE);
    assign is_ind_two = (dir_sect == ZERO_BYTE) && (dir_off == OFF_IND_TWO);

    always_comb begin
        eff_sect = dir_sect;
        eff_off = dir_off;
        if (is_ind_one) begin
            eff_sect = pointer_one_sector_reg;
            eff_off = pointer_one_offset_reg;
        end else if (is_ind_two) begin
            eff_sect = pointer_two_sector_reg;
            eff_off = pointer_two_offset_reg;
        end
    end

    // ****************************************
    // region decode
    // ****************************************
    sdm_region_t region;
    logic [MEM_IDX_W-1:0] mem_idx;
    sdm_ptr_sel_t ptr_sel;
    logic indirect_self;

    // a pointer aimed at an indirect location itself has no meaning; treat as unused
    assign indirect_self = (is_ind_one || is_ind_two) && (eff_sect == ZERO_BYTE)
        && (eff_off == OFF_IND_ONE || eff_off == OFF_IND_TWO);

    always_comb begin
        region = RGN_NONE;
        mem_idx = '0;
        ptr_sel = PTR_ONE_OFF;
        if (eff_sect < SECT_LIMIT && eff_off >= OFF_GP_FIRST) begin
            region = RGN_GP;
            mem_idx = MEM_IDX_W'({eff_sect[3:0], eff_off[6:0]});
        end else if (eff_sect <= SECT_SFR_LAST && eff_off <= OFF_SFR_LAST) begin
            region = RGN_SFR;
            if (eff_sect == ZERO_BYTE) begin
                unique case (eff_off)
                    OFF_PTR_ONE_OFF: begin
                        region = RGN_PTR;
                        ptr_sel = PTR_ONE_OFF;
                    end
                    OFF_PTR_ONE_SECT: begin
                        region = RGN_PTR;
                        ptr_sel = PTR_ONE_SECT;
                    end
                    OFF_PTR_TWO_OFF: begin
                        region = RGN_PTR;
                        ptr_sel = PTR_TWO_OFF;
                    end
                    OFF_PTR_TWO_SECT: begin
                        region = RGN_PTR;
                        ptr_sel = PTR_TWO_SECT;
                    end
                    default: begin
                        region = RGN_SFR;
                    end
                endcase
            end
            if (indirect_self) begin
                region = RGN_NONE;
            end
        end else if (eff_sect == SECT_LCD && eff_off < LCD_SIZE) begin
            region = RGN_LCD;
            mem_idx = BASE_LCD + MEM_IDX_W'(eff_off);
        end else if (eff_sect == SECT_TK_A && eff_off < TK_SIZE) begin
            region = RGN_TK;
            mem_idx = BASE_TK_A + MEM_IDX_W'(eff_off);
        end else if (eff_sect == SECT_TK_B && eff_off < TK_SIZE) begin
            region = RGN_TK;
            mem_idx = BASE_TK_B + MEM_IDX_W'(eff_off);
        end
    end

    // ****************************************
    // request acceptance
    // ****************************************
    sdm_bop_t bop;
    logic take;
    logic byte_wr;
    logic rmw;
    logic is_mem;
    logic cap_is_mem;
    logic modify;
    logic [DATA_W-1:0] ptr_val;

    assign bop = sdm_bop_t'(bop_i);
    assign busy_o = (state == ST_MODIFY);
    assign take = req_i && !busy_o;
    assign byte_wr = take && we_i && (bop == BOP_BYTE);
    assign rmw = take && we_i && (bop == BOP_SET || bop == BOP_CLR);
    assign is_mem = (region == RGN_GP) || (region == RGN_LCD) || (region == RGN_TK);
    assign cap_is_mem = (cap_region == RGN_GP) || (cap_region == RGN_LCD)
        || (cap_region == RGN_TK);
    assign modify = (state == ST_MODIFY);

    always_comb begin
        unique case (ptr_sel)
            PTR_ONE_OFF: ptr_val = pointer_one_offset_reg;
            PTR_ONE_SECT: ptr_val = pointer_one_sector_reg;
            PTR_TWO_OFF: ptr_val = pointer_two_offset_reg;
            PTR_TWO_SECT: ptr_val = pointer_two_sector_reg;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else if (rmw) begin
            state <= ST_MODIFY;
        end else begin
            state <= ST_IDLE;
        end
    end

    // ****************************************
    // capture of the accepted access
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cap_region <= RGN_NONE;
            cap_idx <= '0;
            cap_ptr <= PTR_ONE_OFF;
            cap_bank <= 1'b0;
            cap_sfr_addr <= '0;
            cap_sfr_wr_ok <= 1'b0;
            cap_hold <= ZERO_BYTE;
            cap_bop <= BOP_NONE;
            cap_bit <= '0;
        end else if (take) begin
            cap_region <= region;
            cap_idx <= mem_idx;
            cap_ptr <= ptr_sel;
            cap_bank <= eff_sect[0];
            cap_sfr_addr <= eff_off[SFR_ADDR_W-2:0];
            cap_sfr_wr_ok <= sfr_used_i && !sfr_ro_i;
            cap_bop <= bop;
            cap_bit <= bit_sel_i;
            if (region == RGN_PTR) begin
                cap_hold <= ptr_val;
            end else if (region == RGN_SFR && sfr_used_i) begin
                cap_hold <= sfr_rdata_i;
            end else begin
                cap_hold <= ZERO_BYTE;
            end
        end
    end

    // ****************************************
    // read-modify-write value
    // ****************************************
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] old_val;
    logic [DATA_W-1:0] bit_mask;
    logic [DATA_W-1:0] new_val;

    assign old_val = cap_is_mem ? mem_q : cap_hold;
    assign bit_mask = ONE_BYTE << cap_bit;
    assign new_val = (cap_bop == BOP_SET) ? (old_val | bit_mask)
        : (old_val & ~bit_mask);

    // ****************************************
    // pointer registers
    // ****************************************
    logic ptr_wr;
    sdm_ptr_sel_t ptr_wsel;
    logic [DATA_W-1:0] ptr_wdata;

    assign ptr_wr = (byte_wr && region == RGN_PTR) || (modify && cap_region == RGN_PTR);
    assign ptr_wsel = modify ? cap_ptr : ptr_sel;
    assign ptr_wdata = modify ? new_val : wdata_i;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pointer_one_sector_reg <= ZERO_BYTE;
            pointer_one_offset_reg <= ZERO_BYTE;
            pointer_two_sector_reg <= ZERO_BYTE;
            pointer_two_offset_reg <= ZERO_BYTE;
        end else if (ptr_wr) begin
            unique case (ptr_wsel)
                PTR_ONE_OFF: pointer_one_offset_reg <= ptr_wdata;
                PTR_ONE_SECT: pointer_one_sector_reg <= ptr_wdata;
                PTR_TWO_OFF: pointer_two_offset_reg <= ptr_wdata;
                PTR_TWO_SECT: pointer_two_sector_reg <= ptr_wdata;
            endcase
        end
    end

    assign pointer_one_sector_reg_o = pointer_one_sector_reg;
    assign pointer_one_offset_reg_o = pointer_one_offset_reg;
    assign pointer_two_sector_reg_o = pointer_two_sector_reg;
    assign pointer_two_offset_reg_o = pointer_two_offset_reg;

    // ****************************************
    // special-function port
    // ****************************************
    // the register file itself lives with its peripherals; only decode and protection here
    assign sfr_bank_o = modify ? cap_bank : eff_sect[0];
    assign sfr_addr_o = modify ? cap_sfr_addr : eff_off[SFR_ADDR_W-2:0];
    assign sfr_wdata_o = modify ? new_val : wdata_i;
    assign sfr_rd_o = take && region == RGN_SFR && (!we_i || rmw);
    assign sfr_we_o = (byte_wr && region == RGN_SFR && sfr_used_i && !sfr_ro_i)
        || (modify && cap_region == RGN_SFR && cap_sfr_wr_ok);

    // ****************************************
    // storage array
    // ****************************************
    logic ram_en;
    logic ram_we;
    logic [MEM_IDX_W-1:0] ram_addr;
    logic [DATA_W-1:0] ram_wdata;

    // a region of NONE never enables the array, so stray writes are dropped
    assign ram_en = (take && is_mem) || (modify && cap_is_mem);
    assign ram_we = (byte_wr && is_mem) || modify;
    assign ram_addr = modify ? cap_idx : mem_idx;
    assign ram_wdata = modify ? new_val : wdata_i;

    sdm_ram u_ram (
        .sys_clk_i(sys_clk_i),
        .en_i(ram_en),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wdata_i(ram_wdata),
        .rdata_o(mem_q)
    );

    // ****************************************
    // read return
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= take && !we_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= ZERO_BYTE;
        end else begin
            rvalid_o <= rd_pend;
            if (rd_pend) begin
                rdata_o <= old_val;
            end
        end
    end
endmodule

/* File: test/sdm_sfr_model.sv */
module sdm_sfr_model
    import sdm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic bank_i,
    input wire logic [SFR_ADDR_W-2:0] addr_i,
    input wire logic we_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic used_o,
    output logic ro_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] regs [0:31];
    logic [4:0] idx;
    assign idx = {bank_i, addr_i[3:0]};
    assign used_o = (addr_i[6:4] == 3'h1);
    assign ro_o = used_o && (addr_i[3:0] == 4'hF);
    // unused places show junk, so the block itself must return zero
    assign rdata_o = used_o ? regs[idx] : 8'hA5;
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'h3C;
        end
    end
    // stores even read-only places: guarding them is the block's job
    always @(posedge sys_clk_i) begin
        if (we_i) begin
            regs[idx] <= wdata_i;
        end
    end
endmodule

/* File: test/sdm_map_properties.sv */
module sdm_map_properties
    import sdm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [1:0] bop_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic busy_o,
    input wire logic rvalid_o,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic sfr_rd_o,
    input wire logic sfr_we_o,
    input wire logic sfr_bank_o,
    input wire logic [SFR_ADDR_W-2:0] sfr_addr_o,
    input wire logic [DATA_W-1:0] sfr_wdata_o,
    input wire logic sfr_used_i,
    input wire logic sfr_ro_i,
    input wire logic [OFF_W-1:0] pointer_one_offset_reg_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // access timing
    // ****************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_read_answer: assert property (req_i && !busy_o && !we_i |-> ##[2:3] rvalid_o)
        else $error("read not answered in time");
    a_rvalid_cause: assert property (rvalid_o
        |-> $past(req_i && !busy_o && !we_i, 2) || $past(req_i && !busy_o && !we_i, 3))
        else $error("read data without a read");
    a_rdata_hold: assert property (!$stable(rdata_o) |-> rvalid_o)
        else $error("read data moved without valid");
    a_bitop_busy: assert property (req_i && !busy_o && we_i
        && (bop_i == 2'h1 || bop_i == 2'h2) |=> busy_o ##1 !busy_o)
        else $error("bit op busy not one cycle");
    a_busy_cause: assert property (busy_o
        |-> $past(req_i && we_i && !busy_o && (bop_i == 2'h1 || bop_i == 2'h2)))
        else $error("busy without bit op");
    // ****************************************
    // decode
    // ****************************************
    a_sfr_guard: assert property (sfr_we_o |-> sfr_used_i && !sfr_ro_i)
        else $error("write strobe to unused or read-only place");
    a_sfr_byte: assert property (req_i && !busy_o && we_i && bop_i == 2'h0
        && addr_i[11:8] == 4'h1 && !addr_i[7] && sfr_used_i && !sfr_ro_i
        |-> sfr_we_o && sfr_bank_o && sfr_addr_o == addr_i[6:0] && sfr_wdata_o == wdata_i)
        else $error("register write not passed on");
    a_sfr_read: assert property (req_i && !busy_o && !we_i && addr_i[11:8] == 4'h1
        && !addr_i[7] |-> sfr_rd_o && sfr_bank_o && sfr_addr_o == addr_i[6:0])
        else $error("register read strobe missing");
    a_gp_no_sfr: assert property (req_i && !busy_o && addr_i[7]
        |-> !sfr_we_o && !sfr_rd_o) else $error("upper offsets reached register space");
    a_quiet_idle: assert property (!req_i && !busy_o |-> !sfr_we_o && !sfr_rd_o)
        else $error("register strobe without request");
    a_ptr_write: assert property (req_i && !busy_o && we_i && bop_i == 2'h0
        && addr_i == 12'h003 |=> pointer_one_offset_reg_o == $past(wdata_i))
        else $error("pointer not written");
    a_far_zero: assert property (req_i && !busy_o && !we_i && addr_i[11:8] >= 4'hC
        |-> ##[2:3] (rvalid_o && rdata_o == 8'h00)) else $error("absent sector not zero");
endmodule

bind sdm_map sdm_map_properties sdm_map_properties_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .req_i(req_i), .we_i(we_i), .bop_i(bop_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .sfr_rd_o(sfr_rd_o),
    .sfr_we_o(sfr_we_o), .sfr_bank_o(sfr_bank_o), .sfr_addr_o(sfr_addr_o),
    .sfr_wdata_o(sfr_wdata_o), .sfr_used_i(sfr_used_i), .sfr_ro_i(sfr_ro_i),
    .pointer_one_offset_reg_o(pointer_one_offset_reg_o));

/* File: test/tb.sv */
module tb
    import sdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, nrst_i, req_i, we_i, busy_o, rvalid_o, sfr_rd_o, sfr_we_o, sfr_bank_o;
    logic sfr_used_i, sfr_ro_i;
    logic [1:0] bop_i;
    logic [2:0] bit_sel_i;
    logic [11:0] addr_i;
    logic [6:0] sfr_addr_o;
    logic [7:0] wdata_i, rdata_o, sfr_wdata_o, sfr_rdata_i, p1s, p1o, p2s, p2o;
    logic [7:0] rq[$];
    logic [7:0] eq[$];
    int num_errors = 0;
    int cmp_count = 0;
    sdm_map sdm_map_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .we_i(we_i),
        .bop_i(bop_i), .bit_sel_i(bit_sel_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .busy_o(busy_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .sfr_rd_o(sfr_rd_o),
        .sfr_we_o(sfr_we_o), .sfr_bank_o(sfr_bank_o), .sfr_addr_o(sfr_addr_o),
        .sfr_wdata_o(sfr_wdata_o), .sfr_rdata_i(sfr_rdata_i), .sfr_used_i(sfr_used_i),
        .sfr_ro_i(sfr_ro_i), .pointer_one_sector_reg_o(p1s), .pointer_one_offset_reg_o(p1o),
        .pointer_two_sector_reg_o(p2s), .pointer_two_offset_reg_o(p2o));
    sdm_sfr_model sdm_sfr_model_i (.sys_clk_i(sys_clk_i), .bank_i(sfr_bank_o),
        .addr_i(sfr_addr_o), .we_i(sfr_we_o), .wdata_i(sfr_wdata_o), .rdata_o(sfr_rdata_i),
        .used_o(sfr_used_i), .ro_o(sfr_ro_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // one capture per cycle that valid is high, taken mid-cycle where the output has settled
    always @(negedge sys_clk_i) begin
        if (rvalid_o === 1'b1) begin
            rq.push_back(rdata_o);
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    // request stays up so the next call lands in the very next cycle
    task automatic acc(input logic w, input logic [1:0] b, input logic [2:0] bs,
                       input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        req_i = 1'b1;
        we_i = w;
        bop_i = b;
        bit_sel_i = bs;
        addr_i = a;
        wdata_i = d;
    endtask
    task automatic idle();
        @(negedge sys_clk_i);
        req_i = 1'b0;
        we_i = 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        acc(1'b1, 2'h0, 3'h0, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        acc(1'b0, 2'h0, 3'h0, a, 8'h00);
        eq.push_back(e);
    endtask
    task automatic bit_op(input logic [1:0] b, input logic [2:0] bs, input logic [11:0] a);
        acc(1'b1, b, bs, a, 8'h00);
        idle();
        cmp1(busy_o, 1'b1);
    endtask
    task automatic flush();
        idle();
        repeat (4) @(negedge sys_clk_i);
        cmp8(8'(rq.size()), 8'(eq.size()));
        while (eq.size() > 0 && rq.size() > 0) begin
            cmp8(rq.pop_front(), eq.pop_front());
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        cmp8({p1s | p2s, p1o | p2o} == 16'h0000 ? 8'h00 : 8'hFF, 8'h00);
        cmp1(busy_o | rvalid_o, 1'b0);
    endtask
    task automatic t_gp();
        for (int s = 0; s < 12; s++) wr({4'(s), 8'h80}, 8'(s * 17));
        for (int s = 0; s < 12; s++) wr({4'(s), 8'hFF}, 8'(8'hF0 ^ s));
        for (int s = 0; s < 12; s++) rd({4'(s), 8'h80}, 8'(s * 17));
        for (int s = 0; s < 12; s++) rd({4'(s), 8'hFF}, 8'(8'hF0 ^ s));
        flush();
    endtask
    task automatic t_regions();
        wr(12'h400, 8'h11);
        wr(12'h42F, 8'h22);
        wr(12'h430, 8'h33);
        wr(12'h500, 8'h44);
        wr(12'h547, 8'h55);
        wr(12'h548, 8'h66);
        wr(12'h647, 8'h77);
        wr(12'h210, 8'h88);
        wr(12'hC80, 8'h99);
        rd(12'h400, 8'h11);
        rd(12'h42F, 8'h22);
        rd(12'h430, 8'h00);
        rd(12'h500, 8'h44);
        rd(12'h547, 8'h55);
        rd(12'h548, 8'h00);
        rd(12'h647, 8'h77);
        rd(12'h210, 8'h00);
        rd(12'hC80, 8'h00);
        rd(12'h480, 8'h44);
        flush();
    endtask
    task automatic t_ind();
        wr(12'h003, 8'h85);
        wr(12'h004, 8'h03);
        wr(12'h00D, 8'h10);
        wr(12'h00E, 8'h04);
        idle();
        cmp8(p1o, 8'h85);
        cmp8(p1s, 8'h03);
        cmp8(p2o, 8'h10);
        cmp8(p2s, 8'h04);
        wr(12'h002, 8'h5A);
        wr(12'h00C, 8'hC3);
        rd(12'h385, 8'h5A);
        rd(12'h410, 8'hC3);
        rd(12'h002, 8'h5A);
        rd(12'h00E, 8'h04);
        flush();
    endtask
    task automatic t_bits();
        wr(12'h290, 8'h00);
        bit_op(2'h1, 3'h3, 12'h290);
        bit_op(2'h1, 3'h7, 12'h290);
        bit_op(2'h2, 3'h3, 12'h290);
        acc(1'b1, 2'h3, 3'h0, 12'h290, 8'hFF);
        bit_op(2'h1, 3'h0, 12'h011);
        bit_op(2'h2, 3'h2, 12'h011);
        bit_op(2'h1, 3'h0, 12'h01F);
        rd(12'h290, 8'h80);
        rd(12'h011, 8'h39);
        rd(12'h01F, 8'h3C);
        flush();
    endtask
    task automatic t_sfr();
        wr(12'h115, 8'hA7);
        wr(12'h01F, 8'h00);
        wr(12'h050, 8'h66);
        rd(12'h115, 8'hA7);
        rd(12'h01F, 8'h3C);
        rd(12'h050, 8'h00);
        rd(12'h17F, 8'h00);
        flush();
    endtask
    task automatic results();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        nrst_i = 1'b0;
        req_i = 1'b0;
        we_i = 1'b0;
        bop_i = 2'h0;
        bit_sel_i = 3'h0;
        addr_i = 12'h000;
        wdata_i = 8'h00;
        repeat (8) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_gp();
        t_regions();
        t_ind();
        t_bits();
        t_sfr();
        results();
    end
endmodule
